/* File: core/sbc_regs.svh */
// register offsets, field positions and constants of the bridge control
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH
`define SBC_CTRL_OFS   4'h0
`define SBC_STAT_OFS   4'h4
`define SBC_CURR_OFS   4'h8
`define SBC_CTRL_RST   4'h0
`define SBC_CTRL_IDX   0
`define SBC_CTRL_SLEEP 1
`define SBC_CTRL_DEC   3:2
`define SBC_HOME_POS   7'h10
`define SBC_FULL_OFS   7'h10
`define SBC_COS_SHIFT  7'h20
`define SBC_QTR        6'h20
`define SBC_HOME_PCT   7'h47
`define SBC_FULL_PCT   7'h46
`define SBC_RESP_OK    2'h0
`define SBC_RESP_ERR   2'h2
`endif

/* File: core/sbc_pkg.sv */
// types of the bridge control block
package sbc_pkg;
  // encoding doubles as log2 of the 1/32 position increment
  typedef enum logic [2:0] {
    SBC_R32   = 3'h0,
    SBC_R16   = 3'h1,
    SBC_R8    = 3'h2,
    SBC_R4    = 3'h3,
    SBC_R2    = 3'h4,
    SBC_RFULL = 3'h5
  } sbc_res_t;

  typedef struct packed {
    logic       step_s1, step_s2, step_s3;
    logic       dir_s1, dir_s2, up_s1, up_s2;
    logic       lo_s1, lo_s2, loz_s1, loz_s2;
    logic       oen_s1, oen_s2, lock_s1, lock_s2;
    logic [1:0] pdir_s1, pdir_s2, pen_s1, pen_s2;
    logic [6:0] pos;
    sbc_res_t   res;
    logic       upd_d1, upd_d2;
    logic [6:0] mag_a, mag_b;
    logic       neg_a, neg_b;
    logic [1:0] force_slow;
    logic [1:0] out_pos, out_pos_oe, out_neg, out_neg_oe;
    logic [3:0] ctrl;
    logic       awready, wready, aw_have, w_have;
    logic [3:0] awaddr;
    logic [3:0] wdata;
    logic       wstrb0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready, rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sbc_state_t;
endpackage

/* File: core/sbc_sine_rom.sv */
// quarter-wave winding current table, registered read
`timescale 1ns/100ps
module sbc_sine_rom #(
  parameter int AW = 6,
  parameter int DW = 7
) (
  input  wire logic          CLK,
  input  wire logic          RESET,
  input  wire logic [AW-1:0] addr,
  output logic      [DW-1:0] data_r
);
  logic [DW-1:0] data_nxt;

  // percent of full scale, index 0 = 0 deg, 32 = 90 deg
  always_comb begin
    case (addr)
      6'h00: data_nxt = 7'h00;
      6'h01: data_nxt = 7'h05;
      6'h02: data_nxt = 7'h0a;
      6'h03: data_nxt = 7'h0f;
      6'h04: data_nxt = 7'h14;
      6'h05: data_nxt = 7'h18;
      6'h06: data_nxt = 7'h1d;
      6'h07: data_nxt = 7'h22;
      6'h08: data_nxt = 7'h26;
      6'h09: data_nxt = 7'h2b;
      6'h0a: data_nxt = 7'h2f;
      6'h0b: data_nxt = 7'h33;
      6'h0c: data_nxt = 7'h38;
      6'h0d: data_nxt = 7'h3c;
      6'h0e: data_nxt = 7'h3f;
      6'h0f: data_nxt = 7'h43;
      6'h10: data_nxt = 7'h47;
      6'h11: data_nxt = 7'h4a;
      6'h12: data_nxt = 7'h4d;
      6'h13: data_nxt = 7'h50;
      6'h14: data_nxt = 7'h53;
      6'h15: data_nxt = 7'h56;
      6'h16: data_nxt = 7'h58;
      6'h17: data_nxt = 7'h5a;
      6'h18: data_nxt = 7'h5c;
      6'h19: data_nxt = 7'h5e;
      6'h1a: data_nxt = 7'h60;
      6'h1b: data_nxt = 7'h61;
      6'h1c: data_nxt = 7'h62;
      6'h1d: data_nxt = 7'h63;
      default: data_nxt = 7'h64;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      data_r <= '0;
    end else begin
      data_r <= data_nxt;
    end
  end
endmodule

/* File: core/sbc_top.sv */
// dual bridge phase/enable decoder and step/direction indexer
`timescale 1ns/100ps
`include "sbc_regs.svh"
module sbc_top
  import sbc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        STEP,
  input  wire logic        STEP_DIRECTION,
  input  wire logic [1:0]  BRIDGE_DIRECTION_IN,
  input  wire logic [1:0]  BRIDGE_DRIVE_ENABLE,
  input  wire logic        MODE_SELECT_UPPER,
  input  wire logic        MODE_SELECT_LOWER_TRILEVEL,
  input  wire logic        MODE_SELECT_LOWER_TRILEVEL_Z,
  input  wire logic        OUTPUT_STAGE_ENABLE_N,
  input  wire logic        SUPPLY_LOCKOUT,
  output logic      [1:0]  BRIDGE_OUT_POS,
  output logic      [1:0]  BRIDGE_OUT_POS_OE,
  output logic      [1:0]  BRIDGE_OUT_NEG,
  output logic      [1:0]  BRIDGE_OUT_NEG_OE,
  output logic      [6:0]  WINDING_A_PCT,
  output logic      [6:0]  WINDING_B_PCT,
  output logic      [1:0]  SLOW_DECAY_FORCE,
  output logic      [1:0]  INDEXER_DECAY_SELECT,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  sbc_state_t s_r, s_nxt;
  logic [6:0] rom_a, rom_b, pos_cos;
  logic       step_edge, go_home;
  sbc_res_t   res_pin;

  // ****************************************************
  // position stepping
  // ****************************************************
  // next valid position for resolution r; full step rides on 45 deg
  function automatic logic [6:0] sbc_next(input logic [6:0] p,
                                          input sbc_res_t r,
                                          input logic fwd);
    logic [6:0] off, inc, t, al;
    off = (r == SBC_RFULL) ? `SBC_FULL_OFS : 7'h00;
    inc = 7'h01 << r;
    t   = p - off;
    al  = t & ~(inc - 7'h01);
    if (fwd) begin
      t = al + inc;
    end else if (t == al) begin
      t = t - inc;
    end else begin
      t = al;
    end
    return 7'(t + off);
  endfunction

  function automatic logic [5:0] sbc_fold(input logic [6:0] p);
    return p[5] ? 6'(`SBC_QTR - {1'b0, p[4:0]}) : {1'b0, p[4:0]};
  endfunction

  assign pos_cos = 7'(s_r.pos + `SBC_COS_SHIFT);

  sbc_sine_rom #(.AW(6), .DW(7)) u_rom_a (
    .CLK    (CLK),
    .RESET  (RESET),
    .addr   (sbc_fold(pos_cos)),
    .data_r (rom_a)
  );
  sbc_sine_rom #(.AW(6), .DW(7)) u_rom_b (
    .CLK    (CLK),
    .RESET  (RESET),
    .addr   (sbc_fold(s_r.pos)),
    .data_r (rom_b)
  );

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    s_nxt = s_r;
    // two-stage synchronisers for every pin
    s_nxt.step_s1 = STEP;
    s_nxt.step_s2 = s_r.step_s1;
    s_nxt.step_s3 = s_r.step_s2;
    s_nxt.dir_s1  = STEP_DIRECTION;
    s_nxt.dir_s2  = s_r.dir_s1;
    s_nxt.up_s1   = MODE_SELECT_UPPER;
    s_nxt.up_s2   = s_r.up_s1;
    s_nxt.lo_s1   = MODE_SELECT_LOWER_TRILEVEL;
    s_nxt.lo_s2   = s_r.lo_s1;
    s_nxt.loz_s1  = MODE_SELECT_LOWER_TRILEVEL_Z;
    s_nxt.loz_s2  = s_r.loz_s1;
    s_nxt.oen_s1  = OUTPUT_STAGE_ENABLE_N;
    s_nxt.oen_s2  = s_r.oen_s1;
    s_nxt.lock_s1 = SUPPLY_LOCKOUT;
    s_nxt.lock_s2 = s_r.lock_s1;
    s_nxt.pdir_s1 = BRIDGE_DIRECTION_IN;
    s_nxt.pdir_s2 = s_r.pdir_s1;
    s_nxt.pen_s1  = BRIDGE_DRIVE_ENABLE;
    s_nxt.pen_s2  = s_r.pen_s1;

    step_edge = s_r.step_s2 & ~s_r.step_s3;
    go_home   = s_r.lock_s2 | s_r.ctrl[`SBC_CTRL_SLEEP];
    // float sense wins over the level sense
    if (!s_r.up_s2) begin
      res_pin = s_r.loz_s2 ? SBC_R4 : (s_r.lo_s2 ? SBC_R2 : SBC_RFULL);
    end else begin
      res_pin = s_r.loz_s2 ? SBC_R32 : (s_r.lo_s2 ? SBC_R16 : SBC_R8);
    end

    s_nxt.upd_d1 = 1'b0;
    s_nxt.upd_d2 = s_r.upd_d1;
    if (go_home) begin
      s_nxt.pos        = `SBC_HOME_POS;
      s_nxt.res        = SBC_RFULL;
      s_nxt.mag_a      = `SBC_HOME_PCT;
      s_nxt.mag_b      = `SBC_HOME_PCT;
      s_nxt.neg_a      = 1'b0;
      s_nxt.neg_b      = 1'b0;
      s_nxt.force_slow = 2'h0;
      s_nxt.upd_d2     = 1'b0;
    end else begin
      // steps run even with the output stage off
      if (step_edge) begin
        s_nxt.res    = res_pin;
        s_nxt.pos    = sbc_next(s_r.pos, res_pin, s_r.dir_s2);
        s_nxt.upd_d1 = 1'b1;
      end
      // rom data line up with the moved position two cycles on
      if (s_r.upd_d2) begin
        s_nxt.mag_a = (s_r.res == SBC_RFULL) ? `SBC_FULL_PCT : rom_a;
        s_nxt.mag_b = (s_r.res == SBC_RFULL) ? `SBC_FULL_PCT : rom_b;
        s_nxt.neg_a = pos_cos[6] && (rom_a != 7'h00);
        s_nxt.neg_b = s_r.pos[6] && (rom_b != 7'h00);
        s_nxt.force_slow[0] = s_nxt.mag_a > s_r.mag_a;
        s_nxt.force_slow[1] = s_nxt.mag_b > s_r.mag_b;
      end
    end

    // ****************************************************
    // bridge drive
    // ****************************************************
    for (int i = 0; i < 2; i++) begin
      if (go_home || (s_r.ctrl[`SBC_CTRL_IDX] && s_r.oen_s2)) begin
        s_nxt.out_pos[i]    = 1'b0;
        s_nxt.out_neg[i]    = 1'b0;
        s_nxt.out_pos_oe[i] = 1'b0;
        s_nxt.out_neg_oe[i] = 1'b0;
      end else if (s_r.ctrl[`SBC_CTRL_IDX]) begin
        // zero current parks the winding on both low sides
        s_nxt.out_pos_oe[i] = 1'b1;
        s_nxt.out_neg_oe[i] = 1'b1;
        if ((i == 0 ? s_nxt.mag_a : s_nxt.mag_b) == 7'h00) begin
          s_nxt.out_pos[i] = 1'b0;
          s_nxt.out_neg[i] = 1'b0;
        end else begin
          s_nxt.out_pos[i] = ~(i == 0 ? s_nxt.neg_a : s_nxt.neg_b);
          s_nxt.out_neg[i] = (i == 0 ? s_nxt.neg_a : s_nxt.neg_b);
        end
      end else if (s_r.pen_s2[i]) begin
        s_nxt.out_pos[i]    = s_r.pdir_s2[i];
        s_nxt.out_neg[i]    = ~s_r.pdir_s2[i];
        s_nxt.out_pos_oe[i] = 1'b1;
        s_nxt.out_neg_oe[i] = 1'b1;
      end else begin
        s_nxt.out_pos[i]    = 1'b0;
        s_nxt.out_neg[i]    = 1'b0;
        s_nxt.out_pos_oe[i] = ~s_r.up_s2;
        s_nxt.out_neg_oe[i] = ~s_r.up_s2;
      end
    end

    // ****************************************************
    // register bus
    // ****************************************************
    if (s_r.awready && S_AXI_AWVALID) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr  = S_AXI_AWADDR;
    end
    if (s_r.wready && S_AXI_WVALID) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata  = S_AXI_WDATA[3:0];
      s_nxt.wstrb0 = S_AXI_WSTRB[0];
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = `SBC_RESP_OK;
      if ({s_r.awaddr[3:2], 2'h0} == `SBC_CTRL_OFS) begin
        if (s_r.wstrb0) begin
          s_nxt.ctrl = s_r.wdata;
        end
      end else if ({s_r.awaddr[3:2], 2'h0} != `SBC_STAT_OFS
                   && {s_r.awaddr[3:2], 2'h0} != `SBC_CURR_OFS) begin
        s_nxt.bresp = `SBC_RESP_ERR;
      end
    end
    s_nxt.awready = ~s_nxt.aw_have & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_have & ~s_nxt.bvalid;

    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_r.arready && S_AXI_ARVALID) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `SBC_RESP_OK;
      s_nxt.rdata  = 32'h0;
      if ({S_AXI_ARADDR[3:2], 2'h0} == `SBC_CTRL_OFS) begin
        s_nxt.rdata[3:0] = s_r.ctrl;
      end else if ({S_AXI_ARADDR[3:2], 2'h0} == `SBC_STAT_OFS) begin
        s_nxt.rdata[6:0]   = s_r.pos;
        s_nxt.rdata[10:8]  = s_r.res;
        s_nxt.rdata[12]    = s_r.lock_s2;
        s_nxt.rdata[17:16] = s_r.force_slow;
      end else if ({S_AXI_ARADDR[3:2], 2'h0} == `SBC_CURR_OFS) begin
        s_nxt.rdata[15:0] = {s_r.neg_b, s_r.mag_b, s_r.neg_a, s_r.mag_a};
      end else begin
        s_nxt.rresp = `SBC_RESP_ERR;
      end
    end
    s_nxt.arready = ~s_nxt.rvalid;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_r         <= '0;
      s_r.pos     <= `SBC_HOME_POS;
      s_r.res     <= SBC_RFULL;
      s_r.mag_a   <= `SBC_HOME_PCT;
      s_r.mag_b   <= `SBC_HOME_PCT;
      s_r.ctrl    <= `SBC_CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign BRIDGE_OUT_POS       = s_r.out_pos;
  assign BRIDGE_OUT_POS_OE    = s_r.out_pos_oe;
  assign BRIDGE_OUT_NEG       = s_r.out_neg;
  assign BRIDGE_OUT_NEG_OE    = s_r.out_neg_oe;
  assign WINDING_A_PCT        = s_r.mag_a;
  assign WINDING_B_PCT        = s_r.mag_b;
  assign SLOW_DECAY_FORCE     = s_r.force_slow;
  assign INDEXER_DECAY_SELECT = s_r.ctrl[`SBC_CTRL_DEC];
  assign S_AXI_AWREADY        = s_r.awready;
  assign S_AXI_WREADY         = s_r.wready;
  assign S_AXI_BVALID         = s_r.bvalid;
  assign S_AXI_BRESP          = s_r.bresp;
  assign S_AXI_ARREADY        = s_r.arready;
  assign S_AXI_RVALID         = s_r.rvalid;
  assign S_AXI_RDATA          = s_r.rdata;
  assign S_AXI_RRESP          = s_r.rresp;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_pe_dir_high: assert property (
    (!go_home && !s_r.ctrl[`SBC_CTRL_IDX] && s_r.pen_s2[0]
     && s_r.pdir_s2[0]) |=> (BRIDGE_OUT_POS[0] && !BRIDGE_OUT_NEG[0]
     && BRIDGE_OUT_POS_OE[0] && BRIDGE_OUT_NEG_OE[0]))
    else $error("enabled bridge with direction 1 not driven pos");
  a_pe_fast_decay: assert property (
    (!go_home && !s_r.ctrl[`SBC_CTRL_IDX] && !s_r.pen_s2[1]
     && s_r.up_s2) |=> (!BRIDGE_OUT_POS_OE[1] && !BRIDGE_OUT_NEG_OE[1]))
    else $error("disabled bridge not floating");
  a_pe_brake: assert property (
    (!go_home && !s_r.ctrl[`SBC_CTRL_IDX] && !s_r.pen_s2[0]
     && !s_r.up_s2) |=> (BRIDGE_OUT_POS_OE[0] && !BRIDGE_OUT_POS[0]
     && !BRIDGE_OUT_NEG[0]))
    else $error("disabled bridge not braking low");
  a_step_forward: assert property (
    (step_edge && !go_home && s_r.dir_s2)
    |=> (7'(s_r.pos - $past(s_r.pos)) inside {[7'h01:7'h20]}))
    else $error("forward step did not advance position");
  a_step_reverse: assert property (
    (step_edge && !go_home && !s_r.dir_s2)
    |=> (7'($past(s_r.pos) - s_r.pos) inside {[7'h01:7'h20]}))
    else $error("reverse step did not retreat position");
  a_mode_full: assert property (
    (step_edge && !go_home && !s_r.up_s2 && !s_r.lo_s2 && !s_r.loz_s2)
    |=> (s_r.res == SBC_RFULL) ##2 ($past(go_home)
     || WINDING_A_PCT == `SBC_FULL_PCT))
    else $error("full step decode or current wrong");
  a_mode_hold: assert property (
    (!step_edge && !go_home) |=> $stable(s_r.res))
    else $error("resolution changed without a step edge");
  a_home_lockout: assert property (
    s_r.lock_s2 |=> (s_r.pos == `SBC_HOME_POS && !BRIDGE_OUT_POS_OE[0]
     && WINDING_B_PCT == `SBC_HOME_PCT && s_r.res == SBC_RFULL))
    else $error("lockout did not home the indexer");
  a_stage_off: assert property (
    (s_r.ctrl[`SBC_CTRL_IDX] && s_r.oen_s2) |=> (BRIDGE_OUT_POS_OE == 2'h0
     && BRIDGE_OUT_NEG_OE == 2'h0))
    else $error("output stage driven while disabled");
  a_decay_force: assert property (
    (s_r.upd_d2 && !go_home && s_r.res != SBC_RFULL && rom_b > s_r.mag_b)
    |=> SLOW_DECAY_FORCE[1])
    else $error("rising current did not force slow decay");
endmodule

/* File: tb/sbc_mcu_model.sv */
// controller model driving step, direction and mode select pins
`timescale 1ns/100ps
module sbc_mcu_model
  import sbc_pkg::*;
(
  input  wire logic clk,
  output logic      step,
  output logic      step_dir,
  output logic      mode_up,
  output logic      mode_lo,
  output logic      mode_lo_z
);
  logic lo_lvl;
  logic noise;

  initial begin
    step      = 1'b0;
    step_dir  = 1'b1;
    mode_up   = 1'b0;
    lo_lvl    = 1'b0;
    mode_lo_z = 1'b0;
    noise     = 1'b0;
  end

  // a released pin has no pull: its sensed level is garbage
  always @(posedge clk) begin
    noise <= ~noise;
  end
  assign mode_lo = mode_lo_z ? noise : lo_lvl;

  // ****************************************
  // pin tasks
  // ****************************************
  task automatic set_mode(input sbc_res_t r);
    @(posedge clk);
    mode_up   <= r inside {SBC_R32, SBC_R16, SBC_R8};
    mode_lo_z <= r inside {SBC_R32, SBC_R4};
    lo_lvl    <= r inside {SBC_R16, SBC_R2};
  endtask

  // each level lasts three clocks, above the two the sync needs
  task automatic pulse(input logic fwd);
    @(posedge clk);
    step_dir <= fwd;
    repeat (3) @(posedge clk);
    step <= 1'b1;
    repeat (3) @(posedge clk);
    step <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the bridge control block
`timescale 1ns/100ps
module testbench
  import sbc_pkg::*;
;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  wire logic   STEP, STEP_DIRECTION, MODE_SELECT_UPPER;
  wire logic   MODE_SELECT_LOWER_TRILEVEL, MODE_SELECT_LOWER_TRILEVEL_Z;
  logic [1:0]  BRIDGE_DIRECTION_IN, BRIDGE_DRIVE_ENABLE;
  logic        OUTPUT_STAGE_ENABLE_N, SUPPLY_LOCKOUT;
  logic [1:0]  BRIDGE_OUT_POS, BRIDGE_OUT_POS_OE, BRIDGE_OUT_NEG;
  logic [1:0]  BRIDGE_OUT_NEG_OE, SLOW_DECAY_FORCE, INDEXER_DECAY_SELECT;
  logic [6:0]  WINDING_A_PCT, WINDING_B_PCT;
  logic [3:0]  S_AXI_AWADDR, S_AXI_WSTRB, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, S_AXI_RREADY;
  int          error_cnt = 0;
  int          num_checks = 0;
  logic [31:0] seed;
  logic [6:0]  pos, pa, pb;
  sbc_res_t    res;

  localparam logic [6:0] QTR [0:32] = '{7'h64, 7'h64, 7'h64, 7'h63, 7'h62,
    7'h61, 7'h60, 7'h5e, 7'h5c, 7'h5a, 7'h58, 7'h56, 7'h53, 7'h50, 7'h4d,
    7'h4a, 7'h47, 7'h43, 7'h3f, 7'h3c, 7'h38, 7'h33, 7'h2f, 7'h2b, 7'h26,
    7'h22, 7'h1d, 7'h18, 7'h14, 7'h0f, 7'h0a, 7'h05, 7'h00};

  sbc_top u_sbc_top (.CLK, .RESET, .STEP, .STEP_DIRECTION,
    .BRIDGE_DIRECTION_IN, .BRIDGE_DRIVE_ENABLE, .MODE_SELECT_UPPER,
    .MODE_SELECT_LOWER_TRILEVEL, .MODE_SELECT_LOWER_TRILEVEL_Z,
    .OUTPUT_STAGE_ENABLE_N, .SUPPLY_LOCKOUT, .BRIDGE_OUT_POS,
    .BRIDGE_OUT_POS_OE, .BRIDGE_OUT_NEG, .BRIDGE_OUT_NEG_OE, .WINDING_A_PCT,
    .WINDING_B_PCT, .SLOW_DECAY_FORCE, .INDEXER_DECAY_SELECT, .S_AXI_AWADDR,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY);

  sbc_mcu_model u_sbc_mcu_model (.clk(CLK), .step(STEP),
    .step_dir(STEP_DIRECTION), .mode_up(MODE_SELECT_UPPER),
    .mode_lo(MODE_SELECT_LOWER_TRILEVEL),
    .mode_lo_z(MODE_SELECT_LOWER_TRILEVEL_Z));

  always #50 CLK = ~CLK;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction

  // cosine magnitude; sine is the same shifted by a quarter turn
  function automatic logic [6:0] mag(input logic [6:0] p);
    logic [6:0] m;
    m = {1'b0, p[5:0]};
    return QTR[(m <= 7'h20) ? m : 7'h40 - m];
  endfunction

  function automatic logic [6:0] next_pos(input logic [6:0] p,
                                          input sbc_res_t r, input logic f);
    logic [6:0] q;
    logic [6:0] m;
    q = p;
    m = (7'h1 << r) - 7'h1;
    do q = f ? q + 7'h1 : q - 7'h1;
    while (((q - ((r == SBC_RFULL) ? 7'h10 : 7'h0)) & m) != 7'h0);
    return q;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v,
                        output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge CLK);
    S_AXI_AWADDR  <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA   <= v;
    S_AXI_WSTRB   <= 4'hf;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge CLK);
      if (!aw_ok && S_AXI_AWREADY === 1'b1) begin
        aw_ok = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (!w_ok && S_AXI_WREADY === 1'b1) begin
        w_ok = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    while (S_AXI_BVALID !== 1'b1) @(posedge CLK);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge CLK);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do @(posedge CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask

  task automatic do_step(input sbc_res_t r, input logic f);
    logic [31:0] d;
    logic [1:0]  rs;
    logic [6:0]  ea, eb;
    logic        na, nb;
    u_sbc_mcu_model.set_mode(r);
    u_sbc_mcu_model.pulse(f);
    pos = next_pos(pos, r, f);
    ea = (r == SBC_RFULL) ? 7'h46 : mag(pos);
    eb = (r == SBC_RFULL) ? 7'h46 : mag(pos + 7'h60);
    na = pos > 7'h20 && pos < 7'h60;
    nb = pos > 7'h40;
    axi_rd(4'h4, d, rs);
    chk(d & 32'h7ff, {21'h0, r, 1'b0, pos});
    axi_rd(4'h8, d, rs);
    chk(d, {16'h0, nb, eb, na, ea});
    chk({WINDING_B_PCT, WINDING_A_PCT}, {eb, ea});
    if (r != SBC_RFULL && res != SBC_RFULL)
      chk(SLOW_DECAY_FORCE, {eb > pb, ea > pa});
    chk({BRIDGE_OUT_POS_OE, BRIDGE_OUT_NEG_OE},
        OUTPUT_STAGE_ENABLE_N ? 4'h0 : 4'hf);
    if (!OUTPUT_STAGE_ENABLE_N)
      chk({BRIDGE_OUT_POS, BRIDGE_OUT_NEG},
          {~nb & (eb != 0), ~na & (ea != 0), nb, na});
    res = r;
    pa = ea;
    pb = eb;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [1:0]  rs;
    logic [2:0]  r3;
    logic [1:0]  up;
    seed = 32'hebca;
    BRIDGE_DIRECTION_IN = 2'h0;
    BRIDGE_DRIVE_ENABLE = 2'h0;
    OUTPUT_STAGE_ENABLE_N = 1'b0;
    SUPPLY_LOCKOUT = 1'b0;
    {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WSTRB} = '0;
    {S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARADDR, S_AXI_ARVALID} = '0;
    S_AXI_RREADY = 1'b0;
    pos = 7'h10;
    res = SBC_RFULL;
    pa = 7'h47;
    pb = 7'h47;
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    chk({WINDING_B_PCT, WINDING_A_PCT}, {7'h47, 7'h47});
    axi_rd(4'h4, d, rs);
    chk(d & 32'h7ff, 32'h510);
    axi_rd(4'hc, d, rs);
    chk(d, 32'h0);
    chk(rs, 2'h2);
    axi_wr(4'hc, 32'h5, rs);
    chk(rs, 2'h2);
    axi_wr(4'h0, 32'hc, rs);
    axi_rd(4'h0, d, rs);
    chk(d, 32'hc);
    chk(rs, 2'h0);
    chk(INDEXER_DECAY_SELECT, 2'h3);
    $display("registers test done");
    repeat (24) begin
      seed = lfsr(seed);
      r3 = seed[6:4] % 3'h6;
      up = {2{r3 < 3'h3}};
      u_sbc_mcu_model.set_mode(sbc_res_t'(r3));
      BRIDGE_DIRECTION_IN <= seed[1:0];
      BRIDGE_DRIVE_ENABLE <= seed[3:2];
      repeat (4) @(posedge CLK);
      chk({BRIDGE_OUT_POS_OE, BRIDGE_OUT_NEG_OE},
          {2{seed[3:2] | ~up}});
      chk({BRIDGE_OUT_POS & BRIDGE_OUT_POS_OE,
           BRIDGE_OUT_NEG & BRIDGE_OUT_NEG_OE},
          {seed[3:2] & seed[1:0], seed[3:2] & ~seed[1:0]});
    end
    $display("phase enable test done");
    axi_wr(4'h0, 32'h1, rs);
    repeat (5) do_step(SBC_RFULL, 1'b0);
    do_step(SBC_R32, 1'b1);
    do_step(SBC_RFULL, 1'b1);
    do_step(SBC_R2, 1'b1);
    u_sbc_mcu_model.set_mode(SBC_R32);
    repeat (6) @(posedge CLK);
    axi_rd(4'h4, d, rs);
    chk(d[10:8], SBC_R2);
    repeat (48) begin
      seed = lfsr(seed);
      OUTPUT_STAGE_ENABLE_N <= seed[8];
      do_step(sbc_res_t'(seed[6:4] % 3'h6), seed[0]);
    end
    $display("indexer test done");
    SUPPLY_LOCKOUT <= 1'b1;
    u_sbc_mcu_model.pulse(1'b1);
    axi_rd(4'h4, d, rs);
    chk(d & 32'h17ff, 32'h1510);
    chk({BRIDGE_OUT_POS_OE, BRIDGE_OUT_NEG_OE}, 4'h0);
    SUPPLY_LOCKOUT <= 1'b0;
    repeat (4) @(posedge CLK);
    chk({WINDING_B_PCT, WINDING_A_PCT}, {7'h47, 7'h47});
    axi_rd(4'h0, d, rs);
    chk(d, 32'h1);
    pos = 7'h10;
    res = SBC_RFULL;
    do_step(SBC_R16, 1'b1);
    axi_wr(4'h0, 32'h3, rs);
    repeat (4) @(posedge CLK);
    axi_rd(4'h4, d, rs);
    chk(d & 32'h7ff, 32'h510);
    axi_wr(4'h0, 32'h1, rs);
    pos = 7'h10;
    pa = 7'h47;
    pb = 7'h47;
    do_step(SBC_R4, 1'b0);
    $display("lockout and sleep test done");
    summarize();
  end

  // runs far longer than the whole sequence needs
  initial begin
    repeat (30000) @(posedge CLK);
    error_cnt++;
    summarize();
  end
endmodule
